//--- eis_defines.svh
`ifndef EIS_DEFINES_SVH
`define EIS_DEFINES_SVH
`define EIS_ADDR_SYSCTL 16'hFFC4
`define EIS_ADDR_SENSE 16'hFFC6
`define EIS_ADDR_ENABLE 16'hFFC7
`define EIS_ADDR_STATUS 16'hFFC8
`define EIS_ADDR_MASK 16'hFFC9
`define EIS_SYSCTL_RESET 8'h09
`define EIS_SYSCTL_NMI_EDGE 2
`define EIS_SYSCTL_FIXED 3
`define EIS_SENSE_RESET 8'h00
`define EIS_ENABLE_RESET 8'h00
`define EIS_MASK_RESET 2'h0
`define EIS_EV_NMI 0
`define EIS_EV_IRQ 1
`endif

//--- eis_pkg.sv
package eis_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eis_bus_s;
   typedef struct packed {
      logic valid;
      logic nmi;
      logic [2:0] num;
   } eis_req_s;
   typedef enum logic [1:0] {
      EIS_IDLE = 2'b00,
      EIS_ENTRY = 2'b01
   } eis_state_e;
endpackage

//--- eis_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "eis_defines.svh"

// What this block does
// - edge select zero picks falling nmi edge, one picks rising edge.
// - only bit 2 of system control affects interrupt handling.
// - sense bit zero means level sensing, one means falling edge sensing.
// - enabled edge-sensed falling edge is latched until serviced.
// - edges latch even while the cpu mask bit is set.
// - latched edge stays pending after its enable bit is cleared.
// - each enable bit gates one request, zero disables its level request and new edge latches.
// - after reset all requests are disabled and masked.
// - system control resets to 09 hex; bit 3 always reads one, bit 2 selects the nmi edge, other bits are plain storage.
// - the five registers are readable and writable at fixed addresses, status by write-one clear.
// - on entry prefetched code is discarded and its address is the return point.
// - nmi ranks first, then request zero highest down to seven lowest.
// - nmi is raised regardless of the cpu mask bit.
// - cpu mask bit masks all eight requests together.
module eis_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input eis_pkg::eis_bus_s bus,
   input wire logic nmi_pin_n,
   input wire logic [7:0] irq_pin_n,
   input wire logic cpu_mask,
   input wire logic cpu_accept,
   input wire logic [15:0] prefetch_addr,
   output logic [7:0] rdata,
   output eis_pkg::eis_req_s req,
   output logic discard_prefetch,
   output logic [15:0] return_addr,
   output logic irq_out
);
   import eis_pkg::*;

   logic [7:0] sysctl_q;
   logic [7:0] sense_q;
   logic [7:0] enable_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [2:0] nmi_sync_q;
   logic [7:0] irq_s1_q, irq_s2_q, irq_s3_q;
   logic nmi_lvl_q;
   logic [7:0] irq_lvl_q;
   logic nmi_pend_q;
   logic [7:0] edge_pend_q;
   logic [7:0] rdata_d;
   logic nmi_edge;
   logic [7:0] irq_fall;
   logic [7:0] irq_active;
   logic [7:0] irq_gated;
   eis_req_s req_d;
   eis_state_e state_q;
   logic [1:0] ev;

   function automatic logic [2:0] eis_prio(input logic [7:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            n = 3'(i);
         end
      end
      return n;
   endfunction

   // registers, rdata one cycle after rd
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sysctl_q <= `EIS_SYSCTL_RESET;
         sense_q <= `EIS_SENSE_RESET;
         enable_q <= `EIS_ENABLE_RESET;
         mask_q <= `EIS_MASK_RESET;
      end else if (bus.wr) begin
         if (bus.addr == `EIS_ADDR_SYSCTL) begin
            sysctl_q <= bus.wdata | (8'h01 << `EIS_SYSCTL_FIXED);
         end else if (bus.addr == `EIS_ADDR_SENSE) begin
            sense_q <= bus.wdata;
         end else if (bus.addr == `EIS_ADDR_ENABLE) begin
            enable_q <= bus.wdata;
         end else if (bus.addr == `EIS_ADDR_MASK) begin
            mask_q <= bus.wdata[1:0];
         end
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (bus.addr == `EIS_ADDR_SYSCTL) begin
         rdata_d = sysctl_q;
      end else if (bus.addr == `EIS_ADDR_SENSE) begin
         rdata_d = sense_q;
      end else if (bus.addr == `EIS_ADDR_ENABLE) begin
         rdata_d = enable_q;
      end else if (bus.addr == `EIS_ADDR_STATUS) begin
         rdata_d = {6'h00, status_q};
      end else if (bus.addr == `EIS_ADDR_MASK) begin
         rdata_d = {6'h00, mask_q};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus.rd ? rdata_d : 8'h00;
      end
   end

   // pin synchronisers, change counts once stages 2 and 3 agree
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         nmi_sync_q <= 3'h7;
         irq_s1_q <= 8'hFF;
         irq_s2_q <= 8'hFF;
         irq_s3_q <= 8'hFF;
         nmi_lvl_q <= 1'b1;
         irq_lvl_q <= 8'hFF;
      end else begin
         nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin_n};
         irq_s1_q <= irq_pin_n;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
         if (nmi_sync_q[1] == nmi_sync_q[2]) begin
            nmi_lvl_q <= nmi_sync_q[2];
         end
         for (int i = 0; i < 8; i++) begin
            if (irq_s2_q[i] == irq_s3_q[i]) begin
               irq_lvl_q[i] <= irq_s3_q[i];
            end
         end
      end
   end

   assign nmi_edge = sysctl_q[`EIS_SYSCTL_NMI_EDGE] ?
                     (!nmi_lvl_q && (nmi_sync_q[1] == nmi_sync_q[2]) && nmi_sync_q[2]) :
                     (nmi_lvl_q && (nmi_sync_q[1] == nmi_sync_q[2]) && !nmi_sync_q[2]);
   assign irq_fall = irq_lvl_q & ~irq_s3_q & ~(irq_s2_q ^ irq_s3_q);

   // edge latches and nmi pending
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         edge_pend_q <= 8'h00;
         nmi_pend_q <= 1'b0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (sense_q[i] && enable_q[i] && irq_fall[i]) begin
               edge_pend_q[i] <= 1'b1;
            end else if (cpu_accept && req.valid && !req.nmi && req.num == 3'(i)) begin
               edge_pend_q[i] <= 1'b0;
            end
         end
         if (nmi_edge) begin
            nmi_pend_q <= 1'b1;
         end else if (cpu_accept && req.valid && req.nmi) begin
            nmi_pend_q <= 1'b0;
         end
      end
   end

   // level read from pin, gated by enable
   assign irq_active = (sense_q & edge_pend_q) | (~sense_q & ~irq_lvl_q & enable_q);
   assign irq_gated = cpu_mask ? 8'h00 : irq_active;

   always_comb begin
      req_d.valid = 1'b0;
      req_d.nmi = 1'b0;
      req_d.num = 3'h0;
      if (nmi_pend_q) begin
         req_d.valid = 1'b1;
         req_d.nmi = 1'b1;
      end else if (|irq_gated) begin
         req_d.valid = 1'b1;
         req_d.num = eis_prio(irq_gated);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         req <= '0;
      end else if (cpu_accept && req.valid) begin
         req <= '0;
      end else begin
         req <= req_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= EIS_IDLE;
         discard_prefetch <= 1'b0;
         return_addr <= 16'h0000;
      end else begin
         case (state_q)
            EIS_IDLE: begin
               discard_prefetch <= 1'b0;
               if (cpu_accept && req.valid) begin
                  discard_prefetch <= 1'b1;
                  return_addr <= prefetch_addr;
                  state_q <= EIS_ENTRY;
               end
            end
            default: begin
               discard_prefetch <= 1'b0;
               state_q <= EIS_IDLE;
            end
         endcase
      end
   end

   // sticky status, set wins over write-one clear
   assign ev = {|(irq_fall & sense_q & enable_q), nmi_edge};
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_q <= 2'h0;
      end else if (bus.wr && bus.addr == `EIS_ADDR_STATUS) begin
         status_q <= (status_q & ~bus.wdata[1:0]) | ev;
      end else begin
         status_q <= status_q | ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(status_q & mask_q);
      end
   end

   property p_nmi_unmasked;
      @(posedge clk_sys) disable iff (!rst_n)
         nmi_edge && !(cpu_accept && req.valid) ##1 !(cpu_accept && req.valid)
            |=> req.valid && req.nmi;
   endproperty
   a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi not raised");

   property p_latch_masked;
      @(posedge clk_sys) disable iff (!rst_n)
         (|(irq_fall & sense_q & enable_q) && cpu_mask)
            |=> &(edge_pend_q | ~$past(irq_fall & sense_q & enable_q));
   endproperty
   a_latch_masked: assert property (p_latch_masked) else $error("edge not latched");

   property p_keep_pend;
      @(posedge clk_sys) disable iff (!rst_n)
         (|(edge_pend_q & ~enable_q) && !cpu_accept)
            |=> &(edge_pend_q | ~$past(edge_pend_q & ~enable_q));
   endproperty
   a_keep_pend: assert property (p_keep_pend) else $error("pending lost");

   property p_mask_all;
      @(posedge clk_sys) disable iff (!rst_n)
         (cpu_mask && !nmi_pend_q && $past(cpu_mask)) |=> !req.valid || req.nmi || $past(cpu_accept);
   endproperty
   a_mask_all: assert property (p_mask_all) else $error("request leaked mask");

   property p_prio;
      @(posedge clk_sys) disable iff (!rst_n)
         (!nmi_pend_q && irq_gated[0] && !(cpu_accept && req.valid))
            |=> req.valid && !req.nmi && req.num == 3'h0;
   endproperty
   a_prio: assert property (p_prio) else $error("wrong priority");

   property p_return;
      @(posedge clk_sys) disable iff (!rst_n)
         (state_q == EIS_IDLE && cpu_accept && req.valid) |=>
            discard_prefetch && return_addr == $past(prefetch_addr);
   endproperty
   a_return: assert property (p_return) else $error("prefetch not kept");

   property p_clear;
      @(posedge clk_sys) disable iff (!rst_n)
         (cpu_accept && req.valid && !req.nmi && !irq_fall[req.num])
            |=> !edge_pend_q[$past(req.num)];
   endproperty
   a_clear: assert property (p_clear) else $error("latch not cleared");

   // nothing raised from reset without enables
   property p_reset_off;
      @(posedge clk_sys) disable iff (!rst_n)
         (enable_q == 8'h00 && edge_pend_q == 8'h00 && !nmi_pend_q) |=> !req.valid;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("request while disabled");
endmodule // eis_top

//--- eis_ext_dev.sv
`timescale 1ns/1ps
module eis_ext_dev (
   input wire logic clk_sys,
   input wire logic cpu_accept,
   input eis_pkg::eis_req_s req,
   output logic nmi_pin_n,
   output logic [7:0] irq_pin_n
);
   import eis_pkg::*;
   logic [7:0] hold_q;
   initial begin
      nmi_pin_n = 1'b1;
      irq_pin_n = 8'hFF;
      hold_q = 8'h00;
   end
   always @(posedge clk_sys) begin
      if (cpu_accept && req.valid && !req.nmi && hold_q[req.num]) begin
         hold_q[req.num] <= 1'b0;
         irq_pin_n[req.num] <= 1'b1;
      end
   end
   task automatic level(input int i);
      @(posedge clk_sys);
      hold_q[i] <= 1'b1;
      irq_pin_n[i] <= 1'b0;
   endtask
   // wide enough to clear the pin synchroniser
   task automatic pulse(input int i);
      @(posedge clk_sys);
      irq_pin_n[i] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      irq_pin_n[i] <= 1'b1;
   endtask
   task automatic nmi(input logic v);
      @(posedge clk_sys);
      nmi_pin_n <= v;
   endtask
endmodule // eis_ext_dev

//--- tb_top.sv
`timescale 1ns/1ps
`include "eis_defines.svh"
module tb_top;
   import eis_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n;
   eis_bus_s bus;
   logic cpu_mask;
   logic cpu_accept;
   logic [15:0] prefetch_addr;
   logic nmi_pin_n;
   logic [7:0] irq_pin_n;
   logic [7:0] rdata;
   eis_req_s req;
   logic discard_prefetch;
   logic irq_out;
   logic [15:0] return_addr;
   int fail_count = 0;
   int checks_done = 0;
   always #20 clk_sys = ~clk_sys;
   eis_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .nmi_pin_n(nmi_pin_n),
      .irq_pin_n(irq_pin_n), .cpu_mask(cpu_mask), .cpu_accept(cpu_accept),
      .prefetch_addr(prefetch_addr), .rdata(rdata), .req(req),
      .discard_prefetch(discard_prefetch), .return_addr(return_addr), .irq_out(irq_out));
   eis_ext_dev u_ext (.clk_sys(clk_sys), .cpu_accept(cpu_accept), .req(req),
      .nmi_pin_n(nmi_pin_n), .irq_pin_n(irq_pin_n));
   task automatic final_report;
      if (fail_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // waits out pin sync and latch, then compares valid, nmi, num
   task automatic rq(input logic [4:0] e);
      cycles(8);
      chk({11'h000, req}, {11'h000, e});
   endtask
   task automatic accept(input logic [15:0] a);
      @(posedge clk_sys);
      cpu_accept <= 1'b1;
      prefetch_addr <= a;
      @(posedge clk_sys);
      cpu_accept <= 1'b0;
      #1 chk({15'h0000, discard_prefetch}, 16'h0001);
      chk(return_addr, a);
   endtask
   task automatic mask(input logic v);
      @(posedge clk_sys);
      cpu_mask <= v;
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys);
      fail_count++;
      final_report;
   end
   initial begin
      rst_n <= 1'b0;
      bus <= '0;
      cpu_mask <= 1'b0;
      cpu_accept <= 1'b0;
      prefetch_addr <= 16'h0000;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`EIS_ADDR_SYSCTL, 8'h09);
      rd(`EIS_ADDR_SENSE, 8'h00);
      rd(`EIS_ADDR_ENABLE, 8'h00);
      wr(`EIS_ADDR_SENSE, 8'hA5);
      rd(`EIS_ADDR_SENSE, 8'hA5);
      wr(`EIS_ADDR_ENABLE, 8'h5A);
      rd(`EIS_ADDR_ENABLE, 8'h5A);
      wr(`EIS_ADDR_SYSCTL, 8'hF2);
      rd(`EIS_ADDR_SYSCTL, 8'hFA);
      rd(16'hFFC5, 8'h00);
      wr(`EIS_ADDR_SENSE, 8'h00);
      wr(`EIS_ADDR_ENABLE, 8'h00);
      wr(`EIS_ADDR_SYSCTL, 8'h09);
      u_ext.level(2);
      rq(5'h00);
      wr(`EIS_ADDR_ENABLE, 8'h05);
      rq(5'h12);
      u_ext.level(0);
      rq(5'h10);
      mask(1'b1);
      rq(5'h00);
      mask(1'b0);
      rq(5'h10);
      accept(16'h1234);
      rq(5'h12);
      accept(16'h2000);
      rq(5'h00);
      wr(`EIS_ADDR_SENSE, 8'h30);
      wr(`EIS_ADDR_ENABLE, 8'h10);
      mask(1'b1);
      u_ext.pulse(5);
      u_ext.pulse(4);
      wr(`EIS_ADDR_ENABLE, 8'h00);
      mask(1'b0);
      rq(5'h14);
      accept(16'h3000);
      rq(5'h00);
      mask(1'b1);
      u_ext.nmi(1'b0);
      rq(5'h18);
      accept(16'h4000);
      u_ext.nmi(1'b1);
      rq(5'h00);
      wr(`EIS_ADDR_SYSCTL, 8'hFC);
      u_ext.nmi(1'b0);
      rq(5'h00);
      u_ext.nmi(1'b1);
      rq(5'h18);
      accept(16'h5000);
      rq(5'h00);
      rd(`EIS_ADDR_STATUS, 8'h03);
      chk({15'h0000, irq_out}, 16'h0000);
      wr(`EIS_ADDR_MASK, 8'h01);
      cycles(2);
      chk({15'h0000, irq_out}, 16'h0001);
      wr(`EIS_ADDR_STATUS, 8'h01);
      cycles(2);
      chk({15'h0000, irq_out}, 16'h0000);
      rd(`EIS_ADDR_STATUS, 8'h02);
      wr(`EIS_ADDR_STATUS, 8'h02);
      rd(`EIS_ADDR_STATUS, 8'h00);
      final_report;
   end
endmodule // tb_top
